/* File: core/i2css_cond_det.sv */
// start, stop and clock edge detector for the two-wire bus
`timescale 1ns/1ns
`include "i2css_regs.svh"

module i2css_cond_det (
    // clock, reset and enable
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    input  wire logic                    ce,
    // bus lines, already synchronous
    input  wire logic                    scl_i,
    input  wire logic                    sda_i,
    // detected conditions
    output i2css_pkg::i2css_cond_type    cond
);

    logic scl_r;
    logic sda_r;
    logic scl_nxt;
    logic sda_nxt;

    // previous line levels, frozen while ce is low
    always_comb begin
        scl_nxt = scl_r;
        sda_nxt = sda_r;
        if (ce) begin
            scl_nxt = scl_i;
            sda_nxt = sda_i;
        end
    end

    // lines reset to released so an idle bus shows no false clock rise after reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            scl_r <= `I2CSS_LINE_IDLE;
            sda_r <= `I2CSS_LINE_IDLE;
        end else begin
            scl_r <= scl_nxt;
            sda_r <= sda_nxt;
        end
    end

    // sda moving while scl stays high marks start or stop
    always_comb begin
        cond.start    = ce & scl_i & scl_r & sda_r & ~sda_i;
        cond.stop     = ce & scl_i & scl_r & ~sda_r & sda_i;
        cond.scl_rise = ce & scl_i & ~scl_r;
        cond.scl_fall = ce & ~scl_i & scl_r;
    end

    property p_start_shape;
        @(posedge clk) disable iff (!rst_n)
        // history is frozen while ce is low, so only judge after an enabled cycle
        (cond.start && $past(ce)) |-> ($past(sda_i) && !sda_i && scl_i && $past(scl_i));
    endproperty
    a_start_shape: assert property (p_start_shape) else $error("start without sda fall");

endmodule

/* File: core/i2css_ctrl.sv */
// serial slave control/status: address match, busy, direction, ack, wake-up and interrupts
//
// Contract
// - match flag high on equal address, else low
// - busy flag cleared when stop detected
// - busy flag set when start detected
// - direction bit one transmits, zero receives
// - rw flag one means master reads
// - eighth bit after start stored as rw
// - seven address bits msb first compared
//
// Chosen here: the address map and the strobed register port.
`timescale 1ns/1ns
`include "i2css_regs.svh"

module i2css_ctrl (
    // clock, reset, enable
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    // two-wire bus, sda drives low only
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe_n,
    // power and system
    input  wire logic        low_power_i,
    output logic             wakeup_o,
    output logic             tx_mode_o,
    output logic             irq
);

    ////////////////////////////////////////////////////////////////////////////////
    // helpers

    // 7-bit address compare, also used by the checks
    function automatic logic addr_hit(input logic [6:0] rx, input logic [7:0] own);
        addr_hit = (rx == own[`I2CSS_ADDR_HI:`I2CSS_ADDR_LO]);
    endfunction

    i2css_pkg::i2css_cond_type cond;
    i2css_pkg::i2css_bus_type  bus;

    assign bus.addr  = reg_addr;
    assign bus.wdata = reg_wdata;
    assign bus.wr    = reg_wr & ce;
    assign bus.rd    = reg_rd & ce;

    i2css_cond_det u_det (
        .clk   (clk),
        .rst_n (rst_n),
        .ce    (ce),
        .scl_i (scl_i),
        .sda_i (sda_i),
        .cond  (cond)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // frame tracking

    i2css_pkg::i2css_state_type state_r;
    i2css_pkg::i2css_state_type state_nxt;
    logic [3:0]                 cnt_r;
    logic [3:0]                 cnt_nxt;
    logic [6:0]                 sh_r;
    logic [6:0]                 sh_nxt;
    logic                       ack_on_r;
    logic                       ack_on_nxt;
    logic                       drive_r;
    logic                       drive_nxt;
    logic                       last_bit;
    logic                       ev_match;

    logic [7:0]                 own_r;
    logic                       match_r;
    logic                       busy_r;
    logic                       txsel_r;
    logic                       tx_ack_value_r;
    logic                       rw_r;
    logic                       wake_r;

    assign last_bit = cond.scl_rise & (cnt_r == `I2CSS_CNT_LAST);
    assign ev_match = (state_r == i2css_pkg::ST_ADDR) & last_bit & addr_hit(sh_r, own_r);

    // start restarts from any state so repeated starts are caught too
    always_comb begin
        state_nxt  = state_r;
        cnt_nxt    = cnt_r;
        sh_nxt     = sh_r;
        ack_on_nxt = ack_on_r;
        drive_nxt  = drive_r;
        if (cond.start) begin
            state_nxt  = i2css_pkg::ST_ADDR;
            cnt_nxt    = `I2CSS_CNT_ZERO;
            ack_on_nxt = 1'b0;
            drive_nxt  = 1'b0;
        end else if (cond.stop) begin
            state_nxt  = i2css_pkg::ST_IDLE;
            ack_on_nxt = 1'b0;
            drive_nxt  = 1'b0;
        end else begin
            case (state_r)
                i2css_pkg::ST_ADDR: begin
                    if (cond.scl_rise) begin
                        if (last_bit) begin
                            state_nxt = i2css_pkg::ST_ADDR_ACK;
                            cnt_nxt   = `I2CSS_CNT_ZERO;
                        end else begin
                            sh_nxt  = {sh_r[5:0], sda_i};   // msb first
                            cnt_nxt = cnt_r + `I2CSS_CNT_STEP;
                        end
                    end
                end
                i2css_pkg::ST_ADDR_ACK: begin
                    // first fall opens the ninth clock, second fall ends it
                    if (cond.scl_fall) begin
                        if (!ack_on_r) begin
                            ack_on_nxt = 1'b1;
                            drive_nxt  = match_r;
                        end else begin
                            ack_on_nxt = 1'b0;
                            drive_nxt  = 1'b0;
                            state_nxt  = match_r ? i2css_pkg::ST_DATA : i2css_pkg::ST_SKIP;
                        end
                    end
                end
                i2css_pkg::ST_DATA: begin
                    if (cond.scl_rise) begin
                        if (last_bit) begin
                            state_nxt = i2css_pkg::ST_DATA_ACK;
                            cnt_nxt   = `I2CSS_CNT_ZERO;
                        end else begin
                            cnt_nxt = cnt_r + `I2CSS_CNT_STEP;
                        end
                    end
                end
                i2css_pkg::ST_DATA_ACK: begin
                    // receiver acks with the software ack value; transmitter leaves it to master
                    if (cond.scl_fall) begin
                        if (!ack_on_r) begin
                            ack_on_nxt = 1'b1;
                            drive_nxt  = ~txsel_r & ~tx_ack_value_r;
                        end else begin
                            ack_on_nxt = 1'b0;
                            drive_nxt  = 1'b0;
                            state_nxt  = i2css_pkg::ST_DATA;
                        end
                    end
                end
                default: begin
                    state_nxt = state_r;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r  <= i2css_pkg::ST_IDLE;
            cnt_r    <= `I2CSS_CNT_ZERO;
            sh_r     <= 7'h00;
            ack_on_r <= 1'b0;
            drive_r  <= 1'b0;
        end else begin
            state_r  <= state_nxt;
            cnt_r    <= cnt_nxt;
            sh_r     <= sh_nxt;
            ack_on_r <= ack_on_nxt;
            drive_r  <= drive_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // control and status bits

    logic [7:0] own_nxt;
    logic       match_nxt;
    logic       busy_nxt;
    logic       txsel_nxt;
    logic       tx_ack_value_nxt;
    logic       rw_nxt;
    logic       wake_nxt;

    // flags follow the bus; writable bits follow software
    always_comb begin
        own_nxt   = own_r;
        match_nxt = match_r;
        busy_nxt  = busy_r;
        txsel_nxt = txsel_r;
        tx_ack_value_nxt  = tx_ack_value_r;
        rw_nxt    = rw_r;
        wake_nxt  = wake_r;
        if (cond.start) begin
            busy_nxt = 1'b1;
        end else if (cond.stop) begin
            busy_nxt = 1'b0;
        end
        if ((state_r == i2css_pkg::ST_ADDR) && last_bit) begin
            match_nxt = addr_hit(sh_r, own_r);
            rw_nxt    = sda_i;
        end
        if (bus.wr && (bus.addr == `I2CSS_OFS_CTRL)) begin
            txsel_nxt = bus.wdata[`I2CSS_B_TXSEL];
            tx_ack_value_nxt  = bus.wdata[`I2CSS_B_TX_ACK_VALUE];
            wake_nxt  = bus.wdata[`I2CSS_B_WAKE];
        end else if (bus.wr && (bus.addr == `I2CSS_OFS_OWN_ADDR)) begin
            own_nxt = bus.wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            own_r   <= `I2CSS_RST_BYTE;
            match_r <= 1'b0;
            busy_r  <= 1'b0;
            txsel_r <= 1'b0;
            tx_ack_value_r  <= 1'b0;
            rw_r    <= 1'b0;
            wake_r  <= 1'b0;
        end else begin
            own_r   <= own_nxt;
            match_r <= match_nxt;
            busy_r  <= busy_nxt;
            txsel_r <= txsel_nxt;
            tx_ack_value_r  <= tx_ack_value_nxt;
            rw_r    <= rw_nxt;
            wake_r  <= wake_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // interrupts, wake-up and read port

    logic [`I2CSS_EV_NUM-1:0] ev;
    logic [`I2CSS_EV_NUM-1:0] stat_r;
    logic [`I2CSS_EV_NUM-1:0] stat_nxt;
    logic [`I2CSS_EV_NUM-1:0] mask_r;
    logic [`I2CSS_EV_NUM-1:0] mask_nxt;
    logic                     stat_clr;
    logic [7:0]               rdata_r;
    logic [7:0]               rdata_nxt;
    logic                     wake_o_r;
    logic                     wake_o_nxt;

    assign ev[`I2CSS_EV_START] = cond.start;
    assign ev[`I2CSS_EV_STOP]  = cond.stop;
    assign ev[`I2CSS_EV_MATCH] = ev_match;
    assign stat_clr            = bus.rd && (bus.addr == `I2CSS_OFS_IRQ_STAT);

    // read clears status, but an event in the same cycle wins so none is lost
    always_comb begin
        stat_nxt = stat_r;
        mask_nxt = mask_r;
        for (int i = 0; i < `I2CSS_EV_NUM; i++) begin
            stat_nxt[i] = ev[i] | (stat_r[i] & ~stat_clr);
        end
        if (bus.wr && (bus.addr == `I2CSS_OFS_IRQ_MASK)) begin
            mask_nxt = bus.wdata[`I2CSS_EV_NUM-1:0];
        end
    end

    // wake-up is a level held while low power lasts; it stays until software clears the enable
    always_comb begin
        wake_o_nxt = wake_o_r;
        if (!wake_r || !low_power_i) begin
            wake_o_nxt = 1'b0;
        end else if (ev_match) begin
            wake_o_nxt = 1'b1;
        end
    end

    // unmapped offsets read zero; transfer-done and receive-ack bits are not part of this block
    always_comb begin
        rdata_nxt = rdata_r;
        if (bus.rd) begin
            if (bus.addr == `I2CSS_OFS_CTRL) begin
                rdata_nxt = {1'b0, match_r, busy_r, txsel_r, tx_ack_value_r, rw_r, wake_r, 1'b0};
            end else if (bus.addr == `I2CSS_OFS_OWN_ADDR) begin
                rdata_nxt = own_r;
            end else if (bus.addr == `I2CSS_OFS_IRQ_STAT) begin
                rdata_nxt = {5'h00, stat_r};
            end else if (bus.addr == `I2CSS_OFS_IRQ_MASK) begin
                rdata_nxt = {5'h00, mask_r};
            end else begin
                rdata_nxt = `I2CSS_RST_BYTE;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stat_r   <= `I2CSS_RST_EV;
            mask_r   <= `I2CSS_RST_EV;
            rdata_r  <= `I2CSS_RST_BYTE;
            wake_o_r <= 1'b0;
        end else begin
            stat_r   <= stat_nxt;
            mask_r   <= mask_nxt;
            rdata_r  <= rdata_nxt;
            wake_o_r <= ce ? wake_o_nxt : wake_o_r;
        end
    end

    assign reg_rdata = rdata_r;
    assign irq       = |(stat_r & mask_r);
    assign wakeup_o  = wake_o_r;
    assign tx_mode_o = txsel_r;
    assign sda_o     = 1'b0;
    assign sda_oe_n  = ~drive_r;

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    property p_match_set;
        @(posedge clk) disable iff (!rst_n)
        ((state_r == i2css_pkg::ST_ADDR) && last_bit && addr_hit(sh_r, own_r)) |=> match_r;
    endproperty
    a_match_set: assert property (p_match_set) else $error("match flag not set");

    property p_match_clr;
        @(posedge clk) disable iff (!rst_n)
        ((state_r == i2css_pkg::ST_ADDR) && last_bit && !addr_hit(sh_r, own_r)) |=> !match_r;
    endproperty
    a_match_clr: assert property (p_match_clr) else $error("match flag set on miss");

    property p_busy_clr;
        @(posedge clk) disable iff (!rst_n)
        cond.stop |=> (!busy_r && (state_r == i2css_pkg::ST_IDLE));
    endproperty
    a_busy_clr: assert property (p_busy_clr) else $error("busy not cleared by stop");

    property p_busy_set;
        @(posedge clk) disable iff (!rst_n)
        cond.start |=> (busy_r && (state_r == i2css_pkg::ST_ADDR)
            && (cnt_r == `I2CSS_CNT_ZERO));
    endproperty
    a_busy_set: assert property (p_busy_set) else $error("busy not set by start");

    property p_txsel;
        @(posedge clk) disable iff (!rst_n)
        (bus.wr && (bus.addr == `I2CSS_OFS_CTRL))
            |=> (tx_mode_o == $past(reg_wdata[`I2CSS_B_TXSEL]));
    endproperty
    a_txsel: assert property (p_txsel) else $error("direction select not taken");

    property p_rw;
        @(posedge clk) disable iff (!rst_n)
        ((state_r == i2css_pkg::ST_ADDR) && last_bit) |=> (rw_r == $past(sda_i));
    endproperty
    a_rw: assert property (p_rw) else $error("rw flag not eighth bit");

    property p_shift;
        @(posedge clk) disable iff (!rst_n)
        ((state_r == i2css_pkg::ST_ADDR) && cond.scl_rise && !last_bit && !cond.start)
            |=> ((sh_r[0] == $past(sda_i)) && (sh_r[6:1] == $past(sh_r[5:0])));
    endproperty
    a_shift: assert property (p_shift) else $error("address not shifted msb first");

    property p_wake;
        @(posedge clk) disable iff (!rst_n)
        (ev_match && wake_r && low_power_i) |=> wakeup_o;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake-up on match");

    property p_no_wake;
        @(posedge clk) disable iff (!rst_n)
        (ce && !wake_r) |=> !wakeup_o;
    endproperty
    a_no_wake: assert property (p_no_wake) else $error("wake-up while disabled");

    property p_stat_clr;
        @(posedge clk) disable iff (!rst_n)
        // the read returns the bits it clears, and nothing is left behind
        (stat_clr && !(|ev)) |=> ((stat_r == `I2CSS_RST_EV)
            && (reg_rdata[`I2CSS_EV_NUM-1:0] == $past(stat_r)));
    endproperty
    a_stat_clr: assert property (p_stat_clr) else $error("status not cleared by read");

endmodule

/* File: core/i2css_pkg.sv */
// types shared by the serial slave control block
package i2css_pkg;

    // bus conditions seen on the two wires, one-cycle strobes
    typedef struct packed {
        logic start;
        logic stop;
        logic scl_rise;
        logic scl_fall;
    } i2css_cond_type;

    // software register access request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } i2css_bus_type;

    // frame tracking states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_DATA,
        ST_DATA_ACK,
        ST_SKIP
    } i2css_state_type;

endpackage

/* File: core/i2css_regs.svh */
// register offsets, bit positions, reset values and counts of the serial slave control block
`ifndef I2CSS_REGS_SVH
`define I2CSS_REGS_SVH

// register offsets on the plain register port
`define I2CSS_OFS_CTRL      8'h00
`define I2CSS_OFS_OWN_ADDR  8'h01
`define I2CSS_OFS_IRQ_STAT  8'h02
`define I2CSS_OFS_IRQ_MASK  8'h03

// bit positions inside the control/status byte
`define I2CSS_B_MATCH       6
`define I2CSS_B_BUSY        5
`define I2CSS_B_TXSEL       4
`define I2CSS_B_TX_ACK_VALUE        3
`define I2CSS_B_RW          2
`define I2CSS_B_WAKE        1

// own address field sits in bits 7..1
`define I2CSS_ADDR_HI       7
`define I2CSS_ADDR_LO       1

// event bits of the interrupt status and mask bytes
`define I2CSS_EV_START      0
`define I2CSS_EV_STOP       1
`define I2CSS_EV_MATCH      2
`define I2CSS_EV_NUM        3

// reset values
`define I2CSS_RST_BYTE      8'h00
`define I2CSS_RST_EV        3'h0
`define I2CSS_LINE_IDLE     1'b1

// bit counter values: index 7 is the eighth bit after a start
`define I2CSS_CNT_ZERO      4'h0
`define I2CSS_CNT_STEP      4'h1
`define I2CSS_CNT_LAST      4'h7

`endif

/* File: test/i2css_bus_master.sv */
// two-wire bus master model: drives clock and releases or pulls data
`timescale 1ns/1ns

module i2css_bus_master (
    // clock
    input  wire logic clk,
    // resolved data line, pulled up when nobody drives it low
    input  wire logic sda,
    // driven lines: scl level, data high means released
    output logic      scl,
    output logic      sda_rel
);
    localparam int QUARTER = 4;

    // idle bus: both lines high
    initial begin
        scl     = 1'b1;
        sda_rel = 1'b1;
    end

    // one third of a bit period, QUARTER clock cycles
    task automatic quarter;
        repeat (QUARTER) @(posedge clk);
    endtask

    // data falls while clock high; also serves as a repeated start
    task automatic start_cond;
        @(posedge clk);
        sda_rel <= 1'b1;
        quarter();
        scl <= 1'b1;
        quarter();
        sda_rel <= 1'b0;
        quarter();
        scl <= 1'b0;
        quarter();
    endtask

    // data rises while clock high
    task automatic stop_cond;
        @(posedge clk);
        sda_rel <= 1'b0;
        quarter();
        scl <= 1'b1;
        quarter();
        sda_rel <= 1'b1;
        quarter();
    endtask

    // eight bits then a ninth clock on which the slave may pull data low
    task automatic send_byte(input logic [7:0] data, output logic ack);
        @(posedge clk);
        for (int i = 7; i >= 0; i--) begin
            sda_rel <= data[i];
            quarter();
            scl <= 1'b1;
            quarter();
            scl <= 1'b0;
            quarter();
        end
        sda_rel <= 1'b1;
        quarter();
        scl <= 1'b1;
        quarter();
        ack = sda;
        scl <= 1'b0;
        quarter();
    endtask
endmodule

/* File: test/tb.sv */
// self-checking bench for the serial slave control block
`timescale 1ns/1ns
`include "i2css_regs.svh"

module tb;
    logic       clk         = 1'b0;
    logic       rst_n       = 1'b0;
    logic [7:0] reg_addr    = 8'h00;
    logic [7:0] reg_wdata   = 8'h00;
    logic       reg_wr      = 1'b0;
    logic       reg_rd      = 1'b0;
    logic       low_power_i = 1'b0;
    logic       ce          = 1'b1;
    logic [7:0] reg_rdata;
    logic       scl, sda_rel, sda_line, sda_o, sda_oe_n;
    logic       wakeup_o, tx_mode_o, irq;
    int         n_mismatch  = 0;
    int         tests_run   = 0;

    // open-drain data line with pull-up
    assign sda_line = sda_rel & (sda_oe_n | sda_o);

    always #10 clk = ~clk;

    i2css_ctrl dut (
        .clk(clk), .rst_n(rst_n), .ce(ce),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
        .low_power_i(low_power_i), .wakeup_o(wakeup_o), .tx_mode_o(tx_mode_o), .irq(irq)
    );

    i2css_bus_master mst (.clk(clk), .sda(sda_line), .scl(scl), .sda_rel(sda_rel));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // one-cycle strobes, launched just after a rising edge
    task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clk);
        reg_addr  <= addr;
        reg_wdata <= data;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask

    // read data stands from the cycle after the strobe until the next read
    task automatic reg_read(input logic [7:0] addr, output logic [7:0] data);
        @(posedge clk);
        reg_addr <= addr;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        @(negedge clk);
        data = reg_rdata;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        logic [7:0] rd;
        check({7'h00, sda_oe_n}, 8'h01);
        check({6'h00, wakeup_o, irq}, 8'h00);
        check({7'h00, tx_mode_o}, 8'h00);
        for (int a = 0; a < 4; a++) begin
            reg_read(a[7:0], rd);
            check(rd, 8'h00);
        end
    endtask

    // writable bits, read-only flags and an unmapped offset
    task automatic t_regs;
        logic [7:0] rd;
        reg_write(`I2CSS_OFS_OWN_ADDR, 8'hb5);
        reg_read(`I2CSS_OFS_OWN_ADDR, rd);
        check(rd, 8'hb5);
        // a write while the enable is low must leave the register untouched
        @(posedge clk);
        ce <= 1'b0;
        reg_write(`I2CSS_OFS_OWN_ADDR, 8'h11);
        ce <= 1'b1;
        reg_read(`I2CSS_OFS_OWN_ADDR, rd);
        check(rd, 8'hb5);
        reg_write(`I2CSS_OFS_CTRL, 8'hff);
        reg_read(`I2CSS_OFS_CTRL, rd);
        check(rd, 8'h1a);
        check({7'h00, tx_mode_o}, 8'h01);
        reg_write(`I2CSS_OFS_CTRL, 8'h00);
        @(negedge clk);
        check({7'h00, tx_mode_o}, 8'h00);
        reg_write(8'h04, 8'hff);
        reg_read(8'h04, rd);
        check(rd, 8'h00);
        reg_write(`I2CSS_OFS_IRQ_MASK, 8'h07);
        reg_read(`I2CSS_OFS_IRQ_MASK, rd);
        check(rd, 8'h07);
    endtask

    // matching read address, then mismatches in the last and the first address bit
    task automatic t_addr;
        logic [7:0] rd;
        logic       ack;
        mst.start_cond();
        reg_read(`I2CSS_OFS_CTRL, rd);
        check(rd, 8'h20);
        mst.send_byte(8'hb5, ack);
        check({7'h00, ack}, 8'h00);
        reg_read(`I2CSS_OFS_CTRL, rd);
        check(rd, 8'h64);
        check({7'h00, irq}, 8'h01);
        reg_read(`I2CSS_OFS_IRQ_STAT, rd);
        check(rd, 8'h05);
        check({7'h00, irq}, 8'h00);
        mst.start_cond();
        mst.send_byte(8'hb6, ack);
        check({7'h00, ack}, 8'h01);
        reg_read(`I2CSS_OFS_CTRL, rd);
        check(rd, 8'h20);
        mst.start_cond();
        mst.send_byte(8'h34, ack);
        check({7'h00, ack}, 8'h01);
        mst.stop_cond();
        reg_read(`I2CSS_OFS_CTRL, rd);
        check(rd, 8'h00);
        check({7'h00, irq}, 8'h01);
        reg_read(`I2CSS_OFS_IRQ_STAT, rd);
        check(rd, 8'h03);
    endtask

    // data bytes: acked only as receiver with ack value zero
    task automatic t_data;
        logic [7:0] rd;
        logic       ack;
        mst.start_cond();
        mst.send_byte(8'hb4, ack);
        check({7'h00, ack}, 8'h00);
        reg_read(`I2CSS_OFS_CTRL, rd);
        check(rd, 8'h60);
        reg_write(`I2CSS_OFS_CTRL, 8'h00);
        mst.send_byte(8'h3c, ack);
        check({7'h00, ack}, 8'h00);
        reg_write(`I2CSS_OFS_CTRL, 8'h08);
        mst.send_byte(8'hc3, ack);
        check({7'h00, ack}, 8'h01);
        reg_write(`I2CSS_OFS_CTRL, 8'h10);
        mst.send_byte(8'h0f, ack);
        check({7'h00, ack}, 8'h01);
        reg_write(`I2CSS_OFS_CTRL, 8'h00);
        mst.stop_cond();
        reg_read(`I2CSS_OFS_IRQ_STAT, rd);
        check(rd, 8'h07);
    endtask

    // wake-up on match while in low power, released by software
    task automatic t_wake;
        logic [7:0] rd;
        logic       ack;
        reg_write(`I2CSS_OFS_CTRL, 8'h02);
        low_power_i <= 1'b1;
        mst.start_cond();
        mst.send_byte(8'hb5, ack);
        check({7'h00, wakeup_o}, 8'h01);
        reg_write(`I2CSS_OFS_CTRL, 8'h00);
        // wake-up output drops one cycle after the enable bit clears
        repeat (2) @(negedge clk);
        check({7'h00, wakeup_o}, 8'h00);
        @(posedge clk);
        low_power_i <= 1'b0;
        mst.stop_cond();
        reg_read(`I2CSS_OFS_IRQ_STAT, rd);
        check(rd, 8'h07);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_regs();
        t_addr();
        t_data();
        t_wake();
        final_report();
    end

    // the whole run needs just over a thousand cycles; this cuts a hang short
    initial begin
        #200000;
        n_mismatch++;
        final_report();
    end
endmodule
